// >>> rtl/pmg_gating.sv
// Purpose: Peripheral disable register, second bank, with module enables.
// Assumes: Classic Wishbone, 32-bit data, 25 MHz clk_i, synchronous reset.
// Notes:   Enables follow the register one cycle after a write lands.
// Overview of operation
// - Bit 10 set cuts comparator power, clock.
// - Bit 9 set disables calendar clock module.
// - Bit 8 set disables parallel master port.
// - Bit 7 set disables checksum generator.
// - Bit 3 set disables third serial port.
// - Bit 2 set disables third two-wire module.
// - Bit 1 set disables second two-wire module.
//
// Our own choices: the placing of the registers and the Wishbone interface to the registers.
`timescale 1ns/1ps
module pmg_gating
  import pmg_pkg::*;
(
  input  wire logic                  clk_i,
  input  wire logic                  rst_i,
  input  wire logic                  cyc_i,
  input  wire logic                  stb_i,
  input  wire logic                  we_i,
  input  wire logic [PMG_ADDR_W-1:0] adr_i,
  input  wire logic [3:0]            sel_i,
  input  wire logic [PMG_DATA_W-1:0] dat_i,
  output logic      [PMG_DATA_W-1:0] dat_o,
  output logic                       ack_o,
  output logic                       comparator_en_o,
  output logic                       calendar_clock_en_o,
  output logic                       parallel_port_en_o,
  output logic                       checksum_unit_en_o,
  output logic                       serial_port_three_en_o,
  output logic                       two_wire_three_en_o,
  output logic                       two_wire_two_en_o
);
  ////////////////////////////////////////////////////////////////////////////
  // Bus front end.
  logic                   wr_stb;
  logic                   rd_stb;
  logic                   hit;
  logic [PMG_REG_W-1:0]   disable_second_q;
  logic [PMG_REG_W-1:0]   disable_second_d;
  logic [PMG_DATA_W-1:0]  rdata_q;
  logic [PMG_DATA_W-1:0]  rdata_d;
  logic [PMG_NUM_GATES-1:0] off_vec;
  logic [PMG_NUM_GATES-1:0] en_vec;

  pmg_wb_slave u_slave (
    .clk_i    (clk_i),
    .rst_i    (rst_i),
    .cyc_i    (cyc_i),
    .stb_i    (stb_i),
    .we_i     (we_i),
    .ack_o    (ack_o),
    .wr_stb_o (wr_stb),
    .rd_stb_o (rd_stb)
  );

  // Only one register; other addresses are acknowledged, read zero, ignore writes.
  assign hit = (adr_i == PMG_OFF_DISABLE_SECOND);

  ////////////////////////////////////////////////////////////////////////////
  // Gating register.
  // masked write lanes
  always_comb
  begin
    disable_second_d = disable_second_q;
    if (wr_stb && hit)
    begin
      if (sel_i[0])
        disable_second_d[7:0] = dat_i[7:0] & PMG_IMPL_MASK[7:0];
      if (sel_i[1])
        disable_second_d[15:8] = dat_i[15:8] & PMG_IMPL_MASK[15:8];
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      disable_second_q <= PMG_RESET_VALUE;
    else
      disable_second_q <= disable_second_d;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read data, registered so it is valid while ack stands.
  always_comb
  begin
    rdata_d = '0;
    if (cyc_i && stb_i && !we_i && hit)
      rdata_d = {16'h0000, disable_second_q & PMG_IMPL_MASK};
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      rdata_q <= 32'h0000_0000;
    else
      rdata_q <= rdata_d;
  end

  // Read data is held only while the read is acknowledged.
  assign dat_o = rd_stb ? rdata_q : 32'h0000_0000;

  ////////////////////////////////////////////////////////////////////////////
  // Gating outputs.
  // disable bit of each gated module
  assign off_vec[0] = disable_second_q[PMG_BIT_COMPARATOR];
  assign off_vec[1] = disable_second_q[PMG_BIT_CALENDAR];
  assign off_vec[2] = disable_second_q[PMG_BIT_PARALLEL];
  assign off_vec[3] = disable_second_q[PMG_BIT_CHECKSUM];
  assign off_vec[4] = disable_second_q[PMG_BIT_SERIAL_THREE];
  assign off_vec[5] = disable_second_q[PMG_BIT_TWO_WIRE_THREE];
  assign off_vec[6] = disable_second_q[PMG_BIT_TWO_WIRE_TWO];

  // One registered cell per gated module, so enables are glitch free.
  for (genvar g = 0; g < PMG_NUM_GATES; g++)
  begin : g_cell
    pmg_gate_cell u_cell (
      .clk_i    (clk_i),
      .rst_i    (rst_i),
      .off_i    (off_vec[g]),
      .enable_o (en_vec[g])
    );
  end

  assign comparator_en_o        = en_vec[0];
  assign calendar_clock_en_o    = en_vec[1];
  assign parallel_port_en_o     = en_vec[2];
  assign checksum_unit_en_o     = en_vec[3];
  assign serial_port_three_en_o = en_vec[4];
  assign two_wire_three_en_o    = en_vec[5];
  assign two_wire_two_en_o      = en_vec[6];
endmodule : pmg_gating

// >>> shared/pmg_pkg.sv
// Purpose: Constants for the peripheral module gating register block.
// Assumes: Classic Wishbone slave with 32-bit data, one 25 MHz clock.
// Notes:   Each gating bit set to one cuts power and clock of its module.
package pmg_pkg;
  ////////////////////////////////////////////////////////////////////////////
  // Register map.
  localparam int          PMG_ADDR_W             = 4;
  localparam int          PMG_DATA_W             = 32;
  localparam int          PMG_REG_W              = 16;
  localparam logic [3:0]  PMG_OFF_DISABLE_SECOND = 4'h0;
  localparam logic [15:0] PMG_RESET_VALUE        = 16'h0000;
  // Mask of implemented gating bits: 10, 9, 8, 7, 3, 2 and 1.
  localparam logic [15:0] PMG_IMPL_MASK          = 16'h078E;
  ////////////////////////////////////////////////////////////////////////////
  // Field positions.
  localparam int          PMG_BIT_COMPARATOR     = 10;
  localparam int          PMG_BIT_CALENDAR       = 9;
  localparam int          PMG_BIT_PARALLEL       = 8;
  localparam int          PMG_BIT_CHECKSUM       = 7;
  localparam int          PMG_BIT_SERIAL_THREE   = 3;
  localparam int          PMG_BIT_TWO_WIRE_THREE = 2;
  localparam int          PMG_BIT_TWO_WIRE_TWO   = 1;
  localparam int          PMG_NUM_GATES          = 7;
endpackage : pmg_pkg

// >>> rtl/pmg_wb_slave.sv
// Purpose: Classic Wishbone slave front end, one-cycle ack.
// Assumes: Master holds the request until it sees ack.
// Notes:   Ack is registered and dropped in the cycle after it is given.
`timescale 1ns/1ps
module pmg_wb_slave
  import pmg_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  input  wire logic        we_i,
  output logic             ack_o,
  output logic             wr_stb_o,
  output logic             rd_stb_o
);
  logic ack_q;
  logic ack_d;

  // A new access starts only when no ack is pending, giving at most one ack every two clock cycles.
  always_comb
  begin
    ack_d = cyc_i & stb_i & ~ack_q;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      ack_q <= 1'b0;
    else
      ack_q <= ack_d;
  end

  assign ack_o    = ack_q;
  // Effects land on the edge where the master samples ack.
  assign wr_stb_o = ack_q & cyc_i & stb_i & we_i;
  assign rd_stb_o = ack_q & cyc_i & stb_i & ~we_i;
endmodule : pmg_wb_slave

// >>> rtl/pmg_gate_cell.sv
// Purpose: One gating output bit, turning a disable bit into an enable.
// Assumes: Disable bit comes from a register on the same clock.
// Notes:   Enable output is registered so it never glitches.
`timescale 1ns/1ps
module pmg_gate_cell
(
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic off_i,
  output logic      enable_o
);
  logic en_q;
  logic en_d;

  // Enable is the inverse of the disable bit.
  always_comb
  begin
    en_d = ~off_i;
  end

  // After reset every module starts enabled.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      en_q <= 1'b1;
    else
      en_q <= en_d;
  end

  assign enable_o = en_q;
endmodule : pmg_gate_cell

// >>> testbench/pmg_gating_sva.sv
// Purpose: Assertions on the ports of the peripheral gating register.
// Assumes: One clock, synchronous active-high reset.
// Notes:   Enables trail an acked write by two edges.
`timescale 1ns/1ps
module pmg_gating_sva
  import pmg_pkg::*;
(
  input logic        clk_i,
  input logic        rst_i,
  input logic        cyc_i,
  input logic        stb_i,
  input logic        we_i,
  input logic [3:0]  adr_i,
  input logic [3:0]  sel_i,
  input logic [31:0] dat_i,
  input logic [31:0] dat_o,
  input logic        ack_o,
  input logic        comparator_en_o,
  input logic        calendar_clock_en_o,
  input logic        parallel_port_en_o,
  input logic        checksum_unit_en_o,
  input logic        serial_port_three_en_o,
  input logic        two_wire_three_en_o,
  input logic        two_wire_two_en_o
);
  ////////////////////////////////////////
  // Acked write to the mapped register.
  wire wa = ack_o & cyc_i & stb_i & we_i & (adr_i == 4'h0);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // Each enable is the inverse of its bit, so a swapped lane shows here.
  property p_cmp; wa && sel_i[1] |-> ##2 comparator_en_o != $past(dat_i[10], 2); endproperty
  a_cmp: assert property (p_cmp) else $error("comparator enable wrong");
  property p_cal; wa && sel_i[1] |-> ##2 calendar_clock_en_o != $past(dat_i[9], 2); endproperty
  a_cal: assert property (p_cal) else $error("calendar enable wrong");
  property p_par; wa && sel_i[1] |-> ##2 parallel_port_en_o != $past(dat_i[8], 2); endproperty
  a_par: assert property (p_par) else $error("parallel enable wrong");
  property p_crc; wa && sel_i[0] |-> ##2 checksum_unit_en_o != $past(dat_i[7], 2); endproperty
  a_crc: assert property (p_crc) else $error("checksum enable wrong");
  property p_ser; wa && sel_i[0] |-> ##2 serial_port_three_en_o != $past(dat_i[3], 2); endproperty
  a_ser: assert property (p_ser) else $error("serial enable wrong");
  property p_tw3; wa && sel_i[0] |-> ##2 two_wire_three_en_o != $past(dat_i[2], 2); endproperty
  a_tw3: assert property (p_tw3) else $error("two wire three enable wrong");
  property p_tw2; wa && sel_i[0] |-> ##2 two_wire_two_en_o != $past(dat_i[1], 2); endproperty
  a_tw2: assert property (p_tw2) else $error("two wire two enable wrong");
  property p_rd; ack_o && !we_i |-> (dat_o & 32'hFFFFF871) == 32'h0; endproperty
  a_rd: assert property (p_rd) else $error("unimplemented bit read high");
  // Every gated module must come out of reset enabled, not just a few.
  property p_rst; $fell(rst_i) |-> comparator_en_o && calendar_clock_en_o &&
    parallel_port_en_o && checksum_unit_en_o && serial_port_three_en_o &&
    two_wire_three_en_o && two_wire_two_en_o;
  endproperty
  a_rst: assert property (p_rst) else $error("module off after reset");
  // Ack is a one-cycle pulse, so a held request cannot write on two edges in a row.
  property p_ack; ack_o |=> !ack_o; endproperty
  a_ack: assert property (p_ack) else $error("ack held too long");
  // Read data stays zero while ack is low.
  property p_dat; !ack_o |-> dat_o == 32'h0000_0000; endproperty
  a_dat: assert property (p_dat) else $error("read data outside ack");
  // Main scenarios.
  c_wr: cover property (wa);
  c_rd: cover property (ack_o && !we_i);
  c_off: cover property (!comparator_en_o);
endmodule : pmg_gating_sva
bind pmg_gating pmg_gating_sva u_sva (.*);

// >>> testbench/pmg_gating_tb.sv
// Purpose: Self-checking bench for the peripheral gating register.
// Assumes: Ack comes one cycle after the request.
// Notes:   Enables are checked a cycle after they settle.
`timescale 1ns/1ps
module pmg_gating_tb;
  import pmg_pkg::*;
  logic clk_i = 0, rst_i = 1, cyc_i = 0, stb_i = 0, we_i = 0, ack_o;
  logic [3:0] adr_i = 4'h0, sel_i = 4'h0;
  logic [31:0] dat_i = 32'h0, dat_o, r;
  logic comparator_en_o, calendar_clock_en_o, parallel_port_en_o, checksum_unit_en_o;
  logic serial_port_three_en_o, two_wire_three_en_o, two_wire_two_en_o;
  int fail_count = 0, n_tests = 0;
  pmg_gating uut (.*);
  ////////////////////////////////////////
  // Free-running 25 MHz clock.
  initial forever #20 clk_i = ~clk_i;
  task conclude;
    $display("checks %0d failures %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : conclude
  task chk(input logic [31:0] g, input logic [31:0] e);
    n_tests++;
    if (g !== e)
    begin
      fail_count++;
      $display("[FAIL] %0t got %h exp %h", $time, g, e);
    end
  endtask : chk
  // One classic cycle; the wait is bounded so a dead slave cannot hang us.
  task wb(input logic w, input logic [3:0] a, input logic [3:0] s, input logic [31:0] d);
    int i;
    @(posedge clk_i);
    {cyc_i, stb_i, we_i, adr_i, sel_i, dat_i} <= {2'b11, w, a, s, d};
    i = 0;
    do @(posedge clk_i); while (ack_o !== 1'b1 && ++i < 20);
    r = dat_o;
    if (i >= 20) begin chk(0, 1); conclude(); end
    {cyc_i, stb_i} <= 2'b00;
  endtask : wb
  // Read back and compare register and enables.
  task rd_en(input logic [15:0] v);
    repeat (2) @(posedge clk_i);
    #1;
    chk({25'h0, comparator_en_o, calendar_clock_en_o, parallel_port_en_o, checksum_unit_en_o,
      serial_port_three_en_o, two_wire_three_en_o, two_wire_two_en_o},
      {25'h0, ~v[10:7], ~v[3:1]});
    wb(0, 4'h0, 4'hF, 0);
    chk(r, {16'h0, v});
  endtask : rd_en
  // Walk one disable bit at a time, so a crossed enable shows at once.
  task t_bits;
    int pos [7];
    pos = '{PMG_BIT_COMPARATOR, PMG_BIT_CALENDAR, PMG_BIT_PARALLEL, PMG_BIT_CHECKSUM,
      PMG_BIT_SERIAL_THREE, PMG_BIT_TWO_WIRE_THREE, PMG_BIT_TWO_WIRE_TWO};
    foreach (pos[k])
    begin
      wb(1, 4'h0, 4'h3, 32'h1 << pos[k]);
      rd_en(16'h1 << pos[k]);
    end
  endtask : t_bits
  // Unimplemented bits, lane enables, unmapped place, then a reset mid-run.
  task t_edges;
    wb(1, 4'h0, 4'h3, 32'hFFFFFFFF);
    rd_en(16'h078E);
    wb(1, 4'h0, 4'h1, 32'h0);
    rd_en(16'h0700);
    wb(1, 4'h1, 4'h3, 32'h0);
    rd_en(16'h0700);
    wb(0, 4'h1, 4'h3, 0);
    chk(r, 0);
    rst_i <= 1;
    repeat (2) @(posedge clk_i);
    rst_i <= 0;
    rd_en(16'h0);
  endtask : t_edges
  initial
  begin
    repeat (4) @(posedge clk_i);
    rst_i <= 0;
    rd_en(16'h0);
    t_bits();
    t_edges();
    conclude();
  end
endmodule : pmg_gating_tb
